//--- hw/sd3_cic.sv
`timescale 1ns/1ps
`default_nettype none
`include "sd3_regs.svh"
module sd3_cic import sd3_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic clr,
  input  wire logic tick,
  input  wire logic dec,
  input  wire logic mod_bit,
  // result
  output sd3_acc_t  res
);
  localparam sd3_acc_t ONE   = sd3_acc_t'(1);
  localparam sd3_acc_t M_ONE = '1;

  sd3_acc_t integ_q [3];
  sd3_acc_t dly_q   [3];
  sd3_acc_t res_q;
  sd3_acc_t int_in  [4];
  sd3_acc_t cmb_in  [4];

  // bit stream maps to +1 / -1
  assign int_in[0] = mod_bit ? ONE : M_ONE;
  // comb takes the value after this tick's update, so the third output holds only this run's samples
  assign cmb_in[0] = integ_q[2] + integ_q[1];

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_stage
      assign int_in[i+1] = integ_q[i];
      assign cmb_in[i+1] = cmb_in[i] - dly_q[i];
      always_ff @(posedge clk) begin
        if (rst || clr) begin
          integ_q[i] <= '0;
          dly_q[i]   <= '0;
        end else begin
          if (tick)
            integ_q[i] <= integ_q[i] + int_in[i]; // [R1]
          if (dec)
            dly_q[i] <= cmb_in[i]; // [R1]
        end
      end
    end
  endgenerate

  // three integrators and three combs give the cubed sinc response
  always_ff @(posedge clk) begin
    if (rst || clr)
      res_q <= '0;
    else if (dec)
      res_q <= cmb_in[3]; // [R1]
  end

  assign res = res_q;

  a_cic_clear: assert property (@(posedge clk) disable iff (rst) clr |=> res == '0) // [R19]
    else $error("filter not cleared on restart");
  a_cic_hold: assert property (@(posedge clk) disable iff (rst) !dec && !clr |=> $stable(res)) // [R1]
    else $error("filter output moved between decimations");
endmodule
`default_nettype wire

//--- hw/sd3_decimator.sv
// Function
// [R1] cubed sinc filter decimates modulator stream
// [R2] 2.5, 5, 10 SPS reject 50 and 60 Hz
// [R3] 16.6/50 reject 50 Hz, 20/60 reject 60 Hz
// [R4] notches sit at multiples of data rate
// [R5] bandwidth about 0.26 times data rate
// [R6] all rates scale with adc clock
// [R7] first two results discarded, third output
// [R8] first data counts per rate, delay excluded
// [R9] continuous data each one nominal period
// [R10] start on pin rise or command
// [R11] modulator period is sixteen clocks
// [R12] programmable delay before sampling, default fourteen
// [R13] no delay for later continuous readings
// [R14] overhead compensation before output word
// [R15] delay, sampling, overhead in that order
// [R16] suppressed results skip overhead, never readable
// [R17] same sequencing for both filter types
// [R18] filter type zero selects cubed sinc
// [R19] wide counter, restart clears settle count
`timescale 1ns/1ps
`default_nettype none
`include "sd3_regs.svh"
module sd3_decimator import sd3_pkg::*; #(
  parameter int unsigned SIM_SHIFT = 0
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // conversion triggers
  input  wire logic       start_pin,
  input  wire logic       start_cmd,
  // configuration
  input  wire logic       conv_single,
  input  wire logic       filter_type,
  input  wire logic [3:0] data_rate,
  input  wire logic [2:0] delay_sel,
  input  wire sd3_acc_t   offset_cal,
  // modulator stream
  input  wire logic       mod_bit,
  // results
  output logic            busy,
  output logic            data_ready,
  output sd3_acc_t        result
);
  localparam logic [3:0] MOD_LAST = 4'(`SD3_MOD_CLKS - 1);

  // notches follow the period because oversampling_ratio equals it
  localparam sd3_per_t PER_TAB [14] = '{ // [R2] [R3] [R4] [R5]
    `SD3_PER_0, `SD3_PER_1, `SD3_PER_2, `SD3_PER_3,
    `SD3_PER_4, `SD3_PER_5, `SD3_PER_6, `SD3_PER_7,
    `SD3_PER_8, `SD3_PER_9, `SD3_PER_10, `SD3_PER_11,
    `SD3_PER_12, `SD3_PER_13
  };
  localparam logic [`SD3_DLY_W-1:0] DLY_TAB [8] = '{
    `SD3_DLY_0, `SD3_DLY_1, `SD3_DLY_2, `SD3_DLY_3,
    `SD3_DLY_4, `SD3_DLY_5, `SD3_DLY_6, `SD3_DLY_7
  };

  // start pin synchroniser and filtered level
  logic [2:0]             pin_s_q;
  logic                   pin_lvl_q;
  // captured configuration
  logic [3:0]             rate_q;
  logic [2:0]             dsel_q;
  logic                   filt_q;
  logic                   single_q;
  // sequencer
  sd3_state_e             state_q;
  sd3_state_e             state_d;
  logic [3:0]             pre_q;
  sd3_per_t               cnt_q;
  logic [1:0]             settle_q;
  logic                   ovh_on_q;
  logic [6:0]             ovh_cnt_q;
  // outputs
  logic                   drdy_q;
  sd3_acc_t               result_q;
  sd3_acc_t               cic_res;

  wire                    pin_agree;
  wire                    pin_rise;
  wire                    start_ev;
  wire                    tick;
  wire [3:0]              rate_c;
  wire sd3_per_t          per_raw;
  wire sd3_per_t          per_sh;
  wire sd3_per_t          per_eff;
  wire sd3_per_t          per_last;
  wire [`SD3_DLY_W-1:0]   dly_raw;
  wire [`SD3_DLY_W-1:0]   dly_sh;
  wire [`SD3_DLY_W-1:0]   dly_eff;
  wire sd3_per_t          dly_last;
  wire [6:0]              ovh_len;
  wire [6:0]              ovh_last;
  wire [1:0]              need;
  wire                    settled;
  wire                    dly_done;
  wire                    dec;
  wire                    arm;
  wire                    publish;

  // a pin change counts once the second and third stages agree
  assign pin_agree = pin_s_q[1] == pin_s_q[2];
  assign pin_rise  = pin_agree && pin_s_q[2] && !pin_lvl_q; // [R10]
  assign start_ev  = pin_rise || start_cmd; // [R10]

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s_q   <= 3'h0;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_s_q <= {pin_s_q[1:0], start_pin};
      if (pin_agree)
        pin_lvl_q <= pin_s_q[2];
    end
  end

  // codes past the table fall back to the fastest rate
  assign rate_c   = (data_rate > `SD3_RATE_MAX) ? `SD3_RATE_MAX : data_rate;
  assign per_raw  = PER_TAB[rate_q];
  assign per_sh   = per_raw >> SIM_SHIFT;
  assign per_eff  = (per_sh == '0) ? sd3_per_t'(1) : per_sh;
  assign per_last = per_eff - sd3_per_t'(1);
  assign dly_raw  = DLY_TAB[dsel_q];
  assign dly_sh   = dly_raw >> SIM_SHIFT;
  assign dly_eff  = (dly_sh == '0) ? 12'h1 : dly_sh; // [R12]
  assign dly_last = sd3_per_t'(dly_eff) - sd3_per_t'(1);
  assign ovh_len  = (rate_q >= `SD3_OVH_SPLIT) ? `SD3_OVH_SHORT : `SD3_OVH_LONG;
  assign ovh_last = ovh_len - 7'h1;

  // the low-latency path settles each period, sinc3 after two discards
  assign need    = filt_q ? `SD3_SETTLE_LL : `SD3_SETTLE_SINC3; // [R17] [R18]
  assign settled = settle_q >= need; // [R7]

  assign tick     = pre_q == MOD_LAST; // [R6] [R11]
  assign dly_done = (state_q == SD3_DELAY) && tick && (cnt_q == dly_last); // [R12]
  assign dec      = (state_q == SD3_SAMPLE) && tick && (cnt_q == per_last); // [R9]
  assign arm      = dec && settled; // [R16]
  assign publish  = ovh_on_q && tick && (ovh_cnt_q == ovh_last); // [R14]

  always_ff @(posedge clk) begin
    if (rst) begin
      rate_q   <= 4'h0;
      dsel_q   <= 3'h0;
      filt_q   <= 1'b0;
      single_q <= 1'b0;
    end else if (start_ev) begin
      // held for the whole conversion so a mid-run write cannot skew it
      rate_q   <= rate_c;
      dsel_q   <= delay_sel;
      filt_q   <= filter_type; // [R18]
      single_q <= conv_single;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SD3_IDLE: begin
        state_d = SD3_IDLE;
      end
      SD3_DELAY: begin
        if (dly_done)
          state_d = SD3_SAMPLE; // [R15]
      end
      SD3_SAMPLE: begin
        // continuous mode stays here, later readings see no delay
        if (arm && single_q)
          state_d = SD3_FINISH; // [R13]
      end
      SD3_FINISH: begin
        if (publish)
          state_d = SD3_IDLE; // [R15]
      end
      default: begin
        state_d = SD3_IDLE;
      end
    endcase
    if (start_ev)
      state_d = SD3_DELAY; // [R10] [R12]
  end

  always_ff @(posedge clk) begin
    if (rst)
      state_q <= SD3_IDLE;
    else
      state_q <= state_d;
  end

  // modulator period prescaler, realigned to each start
  always_ff @(posedge clk) begin
    if (rst || start_ev)
      pre_q <= 4'h0;
    else
      pre_q <= pre_q + 4'h1; // [R11]
  end

  // one counter for delay and sampling; 17 bits hold the longest period
  always_ff @(posedge clk) begin
    if (rst || start_ev || dly_done || dec)
      cnt_q <= '0; // [R19]
    else if (tick)
      cnt_q <= cnt_q + sd3_per_t'(1); // [R8]
  end

  always_ff @(posedge clk) begin
    if (rst || start_ev)
      settle_q <= 2'h0; // [R19]
    else if (dec && !settled)
      settle_q <= settle_q + 2'h1; // [R7]
  end

  // overhead runs beside sampling; it is shorter than any period
  always_ff @(posedge clk) begin
    if (rst || start_ev) begin
      ovh_on_q  <= 1'b0;
      ovh_cnt_q <= 7'h0;
    end else if (arm) begin
      ovh_on_q  <= 1'b1; // [R14] [R16]
      ovh_cnt_q <= 7'h0;
    end else if (publish) begin
      ovh_on_q  <= 1'b0;
    end else if (tick && ovh_on_q) begin
      ovh_cnt_q <= ovh_cnt_q + 7'h1;
    end
  end

  // only compensated settled words ever reach the result register
  always_ff @(posedge clk) begin
    if (rst) begin
      drdy_q   <= 1'b0;
      result_q <= '0;
    end else begin
      drdy_q <= publish;
      if (publish)
        result_q <= cic_res - offset_cal; // [R14] [R16]
    end
  end

  sd3_cic u_cic (
    .clk     (clk),
    .rst     (rst),
    .clr     (start_ev),
    .tick    (tick && (state_q == SD3_SAMPLE)),
    .dec     (dec),
    .mod_bit (mod_bit),
    .res     (cic_res)
  );

  assign busy       = state_q != SD3_IDLE;
  assign data_ready = drdy_q;
  assign result     = result_q;

  // checking helpers
  logic [23:0] run_q;
  logic        first_q;
  logic [21:0] gap_q;
  logic        seen_q;
  wire  [19:0] exp_ticks;
  wire  [23:0] exp_first;

  assign exp_ticks = 20'(dly_eff) + 20'(per_eff) * (20'(need) + 20'h1) + 20'(ovh_len);
  assign exp_first = {exp_ticks, 4'h0};

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q   <= 24'h0;
      first_q <= 1'b0;
      gap_q   <= 22'h0;
      seen_q  <= 1'b0;
    end else begin
      run_q <= start_ev ? 24'h0 : run_q + 24'h1;
      if (start_ev)
        first_q <= 1'b1;
      else if (drdy_q)
        first_q <= 1'b0;
      gap_q <= (start_ev || dec) ? 22'h0 : gap_q + 22'h1;
      if (start_ev)
        seen_q <= 1'b0;
      else if (dec)
        seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_delay: assert property (start_ev |=> state_q == SD3_DELAY && cnt_q == '0) // [R10]
    else $error("start did not open the delay phase");
  a_delay_once: assert property (state_q == SD3_SAMPLE && !start_ev |=> state_q != SD3_DELAY) // [R13]
    else $error("delay reinserted without a start");
  a_mod_period: assert property (disable iff (rst || start_ev) tick |-> ##16 tick) // [R11]
    else $error("modulator period is not sixteen clocks");
  a_period_gap: assert property (dec && seen_q |-> 22'(gap_q) == 22'({per_eff, 4'h0}) - 22'h1) // [R9]
    else $error("decimation spacing differs from the period");
  a_first_data: assert property (drdy_q && first_q |-> run_q == exp_first) // [R8]
    else $error("first data at the wrong time");
  a_suppress_two: assert property (dec && !filt_q && settle_q < 2'h2 |=> !ovh_on_q ##0 !drdy_q) // [R16]
    else $error("unsettled result entered the overhead");
  a_settled_only: assert property (publish |-> settle_q == need) // [R7]
    else $error("output before the filter settled");
  a_ovh_order: assert property (arm |=> (ovh_on_q && !drdy_q) [*2]) // [R15]
    else $error("overhead skipped for a settled result");
  a_single_stop: assert property (drdy_q && single_q && !$past(start_ev) |-> state_q == SD3_IDLE) // [R15]
    else $error("single conversion kept running");
  a_restart_clear: assert property (start_ev |=> settle_q == 2'h0 && !ovh_on_q) // [R19]
    else $error("restart left stale suppression state");
  a_result_hold: assert property (!publish |=> $stable(result_q)) // [R16]
    else $error("result changed without a publish");

  c_single_done: cover property (single_q && drdy_q);
  c_cont_second: cover property (!single_q && drdy_q ##[1:1000] !single_q && dec);
  c_restart_run: cover property (state_q == SD3_SAMPLE && start_ev);
endmodule
`default_nettype wire

//--- pkg/sd3_pkg.sv
`default_nettype none
`include "sd3_regs.svh"
package sd3_pkg;
  typedef enum logic [1:0] {
    SD3_IDLE,
    SD3_DELAY,
    SD3_SAMPLE,
    SD3_FINISH
  } sd3_state_e;
  typedef logic [`SD3_ACC_W-1:0] sd3_acc_t;
  typedef logic [`SD3_PER_W-1:0] sd3_per_t;
endpackage
`default_nettype wire

//--- pkg/sd3_regs.svh
`ifndef SD3_REGS_SVH
`define SD3_REGS_SVH

// widths
`define SD3_ACC_W       52
`define SD3_PER_W       17
`define SD3_DLY_W       12

// modulator period in adc clocks
`define SD3_MOD_CLKS    16

// discarded results before settled data
`define SD3_SETTLE_SINC3 2'h2
`define SD3_SETTLE_LL    2'h0

// data rate codes 0..13, period in modulator periods
`define SD3_RATE_MAX    4'hd
`define SD3_PER_0       17'h19000
`define SD3_PER_1       17'h0c800
`define SD3_PER_2       17'h06400
`define SD3_PER_3       17'h03c00
`define SD3_PER_4       17'h03200
`define SD3_PER_5       17'h01400
`define SD3_PER_6       17'h010a8
`define SD3_PER_7       17'h00a00
`define SD3_PER_8       17'h00500
`define SD3_PER_9       17'h00280
`define SD3_PER_10      17'h00140
`define SD3_PER_11      17'h00100
`define SD3_PER_12      17'h00080
`define SD3_PER_13      17'h00040

// overhead in modulator periods, short from this rate code up
`define SD3_OVH_LONG    7'h41
`define SD3_OVH_SHORT   7'h28
`define SD3_OVH_SPLIT   4'hb

// conversion delay codes, code 0 is the reset default
`define SD3_DLY_0       12'h00e
`define SD3_DLY_1       12'h01c
`define SD3_DLY_2       12'h038
`define SD3_DLY_3       12'h070
`define SD3_DLY_4       12'h0e0
`define SD3_DLY_5       12'h1c0
`define SD3_DLY_6       12'h380
`define SD3_DLY_7       12'h700

`endif

//--- test/sd3_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sd3_host_model (
  // clock
  input  wire logic clk,
  // start triggers
  output logic      start_pin,
  output logic      start_cmd,
  // modulator stream
  output logic      mod_bit
);
  logic mod_level;
  initial begin
    start_pin = 1'b0;
    start_cmd = 1'b0;
    mod_level = 1'b1;
  end
  // a constant stream keeps the settled sum predictable
  assign mod_bit = mod_level;
  task automatic set_mod(input logic v);
    @(posedge clk);
    mod_level <= v;
  endtask
  // decoder pulse stands for the seventh falling serial edge of the frame
  task automatic send_cmd();
    @(posedge clk);
    start_cmd <= 1'b1;
    @(posedge clk);
    start_cmd <= 1'b0;
  endtask
  task automatic raise_pin();
    @(posedge clk);
    start_pin <= 1'b1;
  endtask
  task automatic drop_pin();
    @(posedge clk);
    start_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/sinc3_decimator_conversion_timing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sd3_regs.svh"
module sinc3_decimator_conversion_timing_tb_top import sd3_pkg::*;;
  logic       clk         = 1'b0;
  logic       rst         = 1'b1;
  logic       conv_single = 1'b1;
  logic       filter_type = 1'b0;
  logic [3:0] data_rate   = 4'hd;
  logic [2:0] delay_sel   = 3'h0;
  sd3_acc_t   offset_cal  = 52'h123;
  wire        start_pin;
  wire        start_cmd;
  wire        mod_bit;
  wire        busy;
  wire        data_ready;
  sd3_acc_t   result;
  int         miscompares  = 0;
  int         total_checks = 0;

  always #2.5 clk = ~clk;

  sd3_decimator #(.SIM_SHIFT(0)) dut_u (
    .clk(clk), .rst(rst), .start_pin(start_pin), .start_cmd(start_cmd),
    .conv_single(conv_single), .filter_type(filter_type), .data_rate(data_rate),
    .delay_sel(delay_sel), .offset_cal(offset_cal), .mod_bit(mod_bit),
    .busy(busy), .data_ready(data_ready), .result(result)
  );
  sd3_host_model host_u (.clk(clk), .start_pin(start_pin), .start_cmd(start_cmd), .mod_bit(mod_bit));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_word(input string what, input sd3_acc_t exp, input sd3_acc_t got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic check_cnt(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic wait_ready(input int limit, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (data_ready !== 1'b1 && cyc < limit);
    if (data_ready !== 1'b1) begin
      $display("[FAIL] data_ready expected 1 seen timeout");
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic quiet(input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (data_ready !== 1'b0) hits++;
    end
  endtask
  task automatic cfg(input logic s, input logic f, input logic [3:0] r, input logic [2:0] d);
    @(posedge clk);
    conv_single <= s;
    filter_type <= f;
    data_rate   <= r;
    delay_sel   <= d;
  endtask
  function automatic sd3_acc_t settled(input longint p, input logic pos);
    // constant input settles to the cube of the decimation length
    return pos ? sd3_acc_t'(p * p * p) - offset_cal : sd3_acc_t'(-(p * p * p)) - offset_cal;
  endfunction

  task automatic t_reset();
    @(posedge clk);
    #1;
    check_word("busy", '0, sd3_acc_t'(busy));
    check_word("data_ready", '0, sd3_acc_t'(data_ready));
    check_word("result", '0, result);
    $display("test reset done");
  endtask
  task automatic t_first_data();
    // low-latency runs keep the sinc3 overhead split, only the discards go
    int     fd [2][4] = '{'{1025, 808, 424, 232}, '{385, 296, 168, 104}};
    longint per [4]   = '{320, 256, 128, 64};
    int     cyc;
    int     hits;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 4; i++) begin
        cfg(1'b1, f[0], 4'(10 + i), 3'h0);
        host_u.send_cmd();
        wait_ready(16 * (14 + fd[f][i]) + 60, cyc);
        // cyc counts edges; the look just after edge n sees what edge n launched
        check_cnt("first data cycles", 16 * (14 + fd[f][i]), cyc);
        check_word("busy single", '0, sd3_acc_t'(busy));
        if (f == 0) begin
          check_word("settled result", settled(per[i], 1'b1), result);
        end
        quiet(1100, hits);
        check_cnt("data after single", 0, hits);
      end
    end
    $display("test first data done");
  endtask
  task automatic t_cont_pin();
    int cyc;
    cfg(1'b0, 1'b0, 4'hd, 3'h0);
    host_u.set_mod(1'b0);
    host_u.raise_pin();
    wait_ready(4000, cyc);
    // the pin passes a synchroniser, so a few edges of slack are allowed
    check_cnt("pin start latency", 1, int'(cyc >= 3938 && cyc <= 3942));
    check_word("negative result", settled(64, 1'b0), result);
    repeat (2) begin
      wait_ready(1100, cyc);
      check_cnt("continuous period", 1024, cyc);
      check_word("busy continuous", 52'h1, sd3_acc_t'(busy));
    end
    host_u.drop_pin();
    $display("test continuous done");
  endtask
  task automatic t_restart();
    int cyc;
    int hits;
    host_u.set_mod(1'b1);
    // a code past the table must run as the fastest rate
    cfg(1'b1, 1'b0, 4'hf, 3'h1);
    host_u.send_cmd();
    quiet(2000, hits);
    check_cnt("data before restart", 0, hits);
    host_u.send_cmd();
    wait_ready(4300, cyc);
    check_cnt("restart first data", 16 * (28 + 232), cyc);
    check_word("restart result", settled(64, 1'b1), result);
    $display("test restart done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_first_data();
    t_cont_pin();
    t_restart();
    give_verdict();
  end
endmodule
`default_nettype wire
